// File: hdl/sfc_pkg.sv
// Purpose: Constants for the serial frame check block (LRC and CRC-16)
// Assumes: One 25 MHz clock, asynchronous active-high reset
// Notes:   How it works
// How it works
// - ASCII framing check is one byte holding an 8-bit value.
// - Sender sums its outgoing message and appends the check.
// - Receiver recomputes the sum and flags any mismatch with received byte.
// - Sum bytes mod 256, then two's complement the result.
// - Leading colon and trailing CR/LF are left out of the sum.
// - Check goes out as two hex characters, upper nibble first.
// - Binary framing check is two bytes forming one 16-bit value.
// - Sender generates the CRC and places it after the last byte.
// - Receiver recomputes the CRC and flags an error on mismatch.
// - CRC register is preset to all ones before the first byte.
// - Each byte is xored into the low eight bits of the register.
// - Each step shifts right, zero into top bit, keeping bit shifted out.
// - If the shifted-out bit is one, xor with polynomial A001.
// - Exactly eight shift steps per byte, then the next byte.
// - Final register value is the result, with no inversion.
// - CRC is sent low byte first, then high byte.
// - Identification reply: addr, func, count, id, run, code, 20-byte name, CRC.
`default_nettype none
package sfc_pkg;
	localparam logic [15:0] SFC_CRC_PRESET  = 16'hFFFF;
	localparam logic [15:0] SFC_CRC_POLY    = 16'hA001;
	localparam logic [3:0]  SFC_CRC_STEPS   = 4'h8;
	localparam logic [7:0]  SFC_LRC_ZERO    = 8'h00;
	localparam logic [7:0]  SFC_CHR_COLON   = 8'h3A;
	localparam logic [7:0]  SFC_CHR_CR      = 8'h0D;
	localparam logic [7:0]  SFC_CHR_LF      = 8'h0A;
	localparam logic [7:0]  SFC_CHR_ZERO    = 8'h30;
	localparam logic [7:0]  SFC_CHR_ALPHA   = 8'h37;
	localparam logic [3:0]  SFC_NIB_NINE    = 4'h9;
	localparam logic [7:0]  SFC_FC_REPORT   = 8'h11;
	localparam logic [7:0]  SFC_ID_COUNT    = 8'h1A;
	localparam logic [5:0]  SFC_NAME_LEN    = 6'h14;
	localparam logic [5:0]  SFC_HDR_LEN     = 6'h09;
	localparam logic [5:0]  SFC_BODY_LEN    = 6'h1D;
	localparam logic [15:0] SFC_SLAVE_ID    = 16'h0001; // Arbitrary value
	localparam logic [15:0] SFC_RUN_IND     = 16'h00FF;
	localparam logic [15:0] SFC_PRODUCT     = 16'h1234; // Arbitrary value
	localparam logic [7:0]  SFC_NAME_FILL   = 8'h20;
	typedef enum logic [2:0] {
		SFC_TX_IDLE, SFC_TX_BODY, SFC_TX_CK0, SFC_TX_CK1, SFC_TX_END0,
		SFC_TX_END1
	} sfc_tx_e;
endpackage : sfc_pkg
`default_nettype wire

// File: hdl/sfc_crc16.sv
// Purpose: Bit-serial reflected CRC-16 engine, one shift per clock
// Assumes: Caller waits for busy low before offering the next byte
// Notes:   Nine clocks per byte (fold, then eight shifts); value reads directly with no inversion
`default_nettype none
module sfc_crc16 (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        clear,
	input  wire logic        byte_valid,
	input  wire logic [7:0]  byte_data,
	output logic             busy,
	output logic [15:0]      crc
);
	logic [15:0] crc_reg;
	logic [15:0] shifted;
	logic [3:0]  step_reg;

	// One shift step with conditional polynomial xor
	always_comb begin
		shifted = {1'b0, crc_reg[15:1]};
		if (crc_reg[0])
			shifted = shifted ^ sfc_pkg::SFC_CRC_POLY;
	end

	// Register update: preset, fold byte, then step
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			crc_reg  <= sfc_pkg::SFC_CRC_PRESET;
			step_reg <= 4'h0;
		end else if (clear) begin
			crc_reg  <= sfc_pkg::SFC_CRC_PRESET;
			step_reg <= 4'h0;
		end else if (step_reg != 4'h0) begin
			crc_reg  <= shifted;
			step_reg <= step_reg - 4'h1;
		end else if (byte_valid) begin
			crc_reg  <= {crc_reg[15:8], crc_reg[7:0] ^ byte_data};
			step_reg <= sfc_pkg::SFC_CRC_STEPS;
		end
	end

	assign busy = (step_reg != 4'h0);
	assign crc  = crc_reg;
endmodule : sfc_crc16
`default_nettype wire

// File: hdl/sfc_lrc.sv
// Purpose: Longitudinal sum accumulator with two's complement result
// Assumes: Framing characters are filtered out by the caller
// Notes:   Carries drop naturally in the 8-bit add
`default_nettype none
module sfc_lrc (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        clear,
	input  wire logic        byte_valid,
	input  wire logic [7:0]  byte_data,
	output logic [7:0]       sum,
	output logic [7:0]       lrc
);
	logic [7:0] sum_reg;

	// Wrapping 8-bit add, ninth bit discarded
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			sum_reg <= 8'h00;
		else if (clear)
			sum_reg <= sfc_pkg::SFC_LRC_ZERO;
		else if (byte_valid)
			sum_reg <= sum_reg + byte_data;
	end

	assign sum = sum_reg;
	assign lrc = (8'hFF - sum_reg) + 8'h01;
endmodule : sfc_lrc
`default_nettype wire

// File: hdl/sfc_frame_check.sv
// Purpose: Frame check for serial register access: LRC and CRC-16 paths
// Assumes: Receive bytes are already decoded from the line; ASCII receive
//          bytes are the binary values of hex pairs
// Notes:   Receiver and sender share one CRC engine, so they never overlap
`default_nettype none
module sfc_frame_check (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        ascii_mode,
	input  wire logic        rx_start,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_end,
	output logic             rx_ready,
	output logic             rx_good,
	output logic             rx_bad,
	output logic [7:0]       rx_func,
	output logic             err_flag,
	input  wire logic        err_clear,
	input  wire logic        tx_start,
	input  wire logic [7:0]  tx_node,
	input  wire logic [7:0]  name_data,
	output logic [4:0]       name_index,
	output logic             tx_valid,
	output logic [7:0]       tx_data,
	input  wire logic        tx_ready,
	output logic             tx_busy
);
	logic        crc_clear;
	logic        crc_feed;
	logic [7:0]  crc_byte;
	logic        crc_busy;
	logic [15:0] crc_val;
	logic        lrc_clear;
	logic        lrc_feed;
	logic [7:0]  lrc_byte;
	logic [7:0]  lrc_sum;
	logic [7:0]  lrc_val;
	logic [7:0]  hist0_reg;
	logic [7:0]  hist1_reg;
	logic [15:0] crc_d1_reg;
	logic [15:0] crc_d2_reg;
	logic [7:0]  sum_d1_reg;
	logic [5:0]  rx_cnt_reg;
	logic        check_reg;
	logic        rx_good_reg;
	logic        rx_bad_reg;
	logic [7:0]  rx_func_reg;
	logic        err_reg;
	logic        is_frame_chr;
	logic        rx_take;
	sfc_pkg::sfc_tx_e tx_state_reg;
	logic [5:0]  tx_idx_reg;
	logic        tx_nib_reg;
	logic        tx_valid_reg;
	logic [7:0]  tx_data_reg;
	logic [7:0]  body_byte;
	logic [7:0]  ck_lrc_reg;
	logic        tx_feed;
	logic        tx_ascii_reg;

	// Shared checkers; receive and send never overlap in time
	sfc_crc16 u_crc (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.clear      (crc_clear),
		.byte_valid (crc_feed),
		.byte_data  (crc_byte),
		.busy       (crc_busy),
		.crc        (crc_val)
	);

	sfc_lrc u_lrc (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.clear      (lrc_clear),
		.byte_valid (lrc_feed),
		.byte_data  (lrc_byte),
		.sum        (lrc_sum),
		.lrc        (lrc_val)
	);

	// Colon and CR/LF never enter the sum
	assign is_frame_chr = (rx_data == sfc_pkg::SFC_CHR_COLON) ||
		(rx_data == sfc_pkg::SFC_CHR_CR) ||
		(rx_data == sfc_pkg::SFC_CHR_LF);
	assign rx_ready = !crc_busy && (tx_state_reg == sfc_pkg::SFC_TX_IDLE);
	assign rx_take  = rx_valid && rx_ready;

	// Engine steering: receive feeds when idle, sender feeds body bytes
	assign crc_clear = rx_start || (tx_start &&
		tx_state_reg == sfc_pkg::SFC_TX_IDLE);
	assign lrc_clear = crc_clear;
	assign tx_feed   = (tx_state_reg == sfc_pkg::SFC_TX_BODY) &&
		tx_valid_reg && tx_ready && (!tx_ascii_reg || tx_nib_reg);
	assign crc_feed  = (rx_take && !ascii_mode) || (tx_feed && !tx_ascii_reg);
	assign crc_byte  = tx_feed ? tx_data_reg : rx_data;
	assign lrc_feed  = (rx_take && ascii_mode && !is_frame_chr) ||
		(tx_feed && tx_ascii_reg);
	assign lrc_byte  = tx_feed ? body_byte : rx_data;

	// Last two bytes, the CRC state before each of them, and the sum before the last one
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hist0_reg  <= 8'h00;
			hist1_reg  <= 8'h00;
			crc_d1_reg <= 16'hFFFF;
			crc_d2_reg <= 16'hFFFF;
			sum_d1_reg <= 8'h00;
			rx_cnt_reg <= 6'h00;
			rx_func_reg <= 8'h00;
		end else if (rx_start) begin
			rx_cnt_reg <= 6'h00;
			crc_d1_reg <= sfc_pkg::SFC_CRC_PRESET;
			crc_d2_reg <= sfc_pkg::SFC_CRC_PRESET;
			sum_d1_reg <= sfc_pkg::SFC_LRC_ZERO;
		end else if (rx_take && !(ascii_mode && is_frame_chr)) begin
			hist0_reg  <= rx_data;
			hist1_reg  <= hist0_reg;
			crc_d2_reg <= crc_d1_reg;
			crc_d1_reg <= crc_val;
			sum_d1_reg <= lrc_sum;
			if (rx_cnt_reg != 6'h3F)
				rx_cnt_reg <= rx_cnt_reg + 6'h01;
			if (rx_cnt_reg == 6'h01)
				rx_func_reg <= rx_data;
		end
	end

	// Compare once the engine has finished the last byte
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			check_reg   <= 1'b0;
			rx_good_reg <= 1'b0;
			rx_bad_reg  <= 1'b0;
		end else begin
			rx_good_reg <= 1'b0;
			rx_bad_reg  <= 1'b0;
			if (rx_end)
				check_reg <= 1'b1;
			else if (check_reg && !crc_busy) begin
				check_reg <= 1'b0;
				if (ascii_mode) begin
					// Check byte excluded: sum before it
					if (rx_cnt_reg < 6'h02 ||
						hist0_reg != (8'hFF - sum_d1_reg) + 8'h01)
						rx_bad_reg <= 1'b1;
					else
						rx_good_reg <= 1'b1;
				end else begin
					// Received low byte first, high byte second
					if (rx_cnt_reg < 6'h03 ||
						{hist0_reg, hist1_reg} != crc_d2_reg)
						rx_bad_reg <= 1'b1;
					else
						rx_good_reg <= 1'b1;
				end
			end
		end
	end

	// Sticky error: a new mismatch wins over a clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			err_reg <= 1'b0;
		else if (rx_bad_reg)
			err_reg <= 1'b1;
		else if (err_clear)
			err_reg <= 1'b0;
	end

	// Bad frames raise no good strobe, so no reply is started
	assign rx_good  = rx_good_reg;
	assign rx_bad   = rx_bad_reg;
	assign rx_func  = rx_func_reg;
	assign err_flag = err_reg;

	// Identification reply body, one byte per index
	always_comb begin
		name_index = 5'h00;
		unique case (tx_idx_reg)
			6'h00: body_byte = tx_node;
			6'h01: body_byte = sfc_pkg::SFC_FC_REPORT;
			6'h02: body_byte = sfc_pkg::SFC_ID_COUNT;
			6'h03: body_byte = sfc_pkg::SFC_SLAVE_ID[15:8];
			6'h04: body_byte = sfc_pkg::SFC_SLAVE_ID[7:0];
			6'h05: body_byte = sfc_pkg::SFC_RUN_IND[15:8];
			6'h06: body_byte = sfc_pkg::SFC_RUN_IND[7:0];
			6'h07: body_byte = sfc_pkg::SFC_PRODUCT[15:8];
			6'h08: body_byte = sfc_pkg::SFC_PRODUCT[7:0];
			default: begin
				name_index = 5'(tx_idx_reg - sfc_pkg::SFC_HDR_LEN);
				body_byte  = (tx_idx_reg < sfc_pkg::SFC_BODY_LEN) ?
					name_data : sfc_pkg::SFC_NAME_FILL;
			end
		endcase
	end

	// Nibble to ASCII hex character
	function automatic logic [7:0] sfc_hex(input logic [3:0] n);
		sfc_hex = (n > sfc_pkg::SFC_NIB_NINE) ?
			8'({4'h0, n}) + sfc_pkg::SFC_CHR_ALPHA :
			8'({4'h0, n}) + sfc_pkg::SFC_CHR_ZERO;
	endfunction : sfc_hex

	// Reply sender: body, check appended, then CR/LF in ASCII mode
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_state_reg <= sfc_pkg::SFC_TX_IDLE;
			tx_idx_reg   <= 6'h00;
			tx_nib_reg   <= 1'b0;
			tx_valid_reg <= 1'b0;
			tx_data_reg  <= 8'h00;
			tx_ascii_reg <= 1'b0;
			ck_lrc_reg   <= 8'h00;
		end else begin
			unique case (tx_state_reg)
				sfc_pkg::SFC_TX_IDLE: begin
					if (tx_start) begin
						tx_ascii_reg <= ascii_mode;
						tx_idx_reg   <= 6'h00;
						tx_nib_reg   <= 1'b0;
						tx_valid_reg <= 1'b0;
						tx_state_reg <= ascii_mode ? sfc_pkg::SFC_TX_END0 :
							sfc_pkg::SFC_TX_BODY;
						tx_data_reg  <= sfc_pkg::SFC_CHR_COLON;
						if (ascii_mode)
							tx_valid_reg <= 1'b1;
					end
				end
				sfc_pkg::SFC_TX_BODY: begin
					if (!tx_valid_reg && !crc_busy) begin
						tx_valid_reg <= 1'b1;
						tx_data_reg  <= !tx_ascii_reg ? body_byte :
							(tx_nib_reg ? sfc_hex(body_byte[3:0]) :
							sfc_hex(body_byte[7:4]));
					end else if (tx_valid_reg && tx_ready) begin
						tx_valid_reg <= 1'b0;
						if (tx_ascii_reg && !tx_nib_reg)
							tx_nib_reg <= 1'b1;
						else begin
							tx_nib_reg <= 1'b0;
							tx_idx_reg <= tx_idx_reg + 6'h01;
							if (tx_idx_reg ==
								sfc_pkg::SFC_BODY_LEN - 6'h01)
								tx_state_reg <= sfc_pkg::SFC_TX_CK0;
						end
					end
				end
				sfc_pkg::SFC_TX_CK0: begin
					// Wait for the engine to finish the last byte
					if (!tx_valid_reg && !crc_busy) begin
						tx_valid_reg <= 1'b1;
						ck_lrc_reg   <= lrc_val;
						tx_data_reg  <= tx_ascii_reg ?
							sfc_hex(lrc_val[7:4]) :
							crc_val[7:0];
					end else if (tx_valid_reg && tx_ready) begin
						tx_valid_reg <= 1'b1;
						tx_data_reg  <= tx_ascii_reg ?
							sfc_hex(ck_lrc_reg[3:0]) :
							crc_val[15:8];
						tx_state_reg <= sfc_pkg::SFC_TX_CK1;
					end
				end
				sfc_pkg::SFC_TX_CK1: begin
					if (tx_ready) begin
						tx_valid_reg <= tx_ascii_reg;
						tx_data_reg  <= sfc_pkg::SFC_CHR_CR;
						tx_state_reg <= tx_ascii_reg ?
							sfc_pkg::SFC_TX_END1 : sfc_pkg::SFC_TX_IDLE;
					end
				end
				sfc_pkg::SFC_TX_END0: begin
					// Opening colon, outside the sum
					if (tx_ready) begin
						tx_valid_reg <= 1'b0;
						tx_state_reg <= sfc_pkg::SFC_TX_BODY;
					end
				end
				sfc_pkg::SFC_TX_END1: begin
					if (tx_ready) begin
						if (tx_data_reg == sfc_pkg::SFC_CHR_CR)
							tx_data_reg <= sfc_pkg::SFC_CHR_LF;
						else begin
							tx_valid_reg <= 1'b0;
							tx_state_reg <= sfc_pkg::SFC_TX_IDLE;
						end
					end
				end
			endcase
		end
	end

	assign tx_valid = tx_valid_reg;
	assign tx_data  = tx_data_reg;
	assign tx_busy  = (tx_state_reg != sfc_pkg::SFC_TX_IDLE);
endmodule : sfc_frame_check
`default_nettype wire

// File: test/sfc_chk.sv
// Purpose: Port assertions for the frame check block
// Assumes: One clock, asynchronous active-high reset
// Notes:   Bound onto the top module by name
`default_nettype none
module sfc_chk (
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       ascii_mode,
	input wire logic       rx_end,
	input wire logic       rx_good,
	input wire logic       rx_bad,
	input wire logic       err_flag,
	input wire logic       err_clear,
	input wire logic       tx_start,
	input wire logic       tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic       tx_ready,
	input wire logic       tx_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// Verdicts: one kind per frame, at the promised distance
	verdict_one_a: assert property (!(rx_good && rx_bad))
		else $error("good and bad verdict together");
	ascii_verdict_a: assert property (rx_end && ascii_mode
		|-> ##2 (rx_good || rx_bad)) else $error("ascii verdict late");
	bin_verdict_a: assert property (rx_end && !ascii_mode
		|-> ##[2:10] (rx_good || rx_bad)) else $error("crc verdict late");
	// Sticky flag: set by a bad frame, kept until cleared
	err_set_a: assert property (rx_bad |=> err_flag)
		else $error("error flag not set");
	err_keep_a: assert property (err_flag && !err_clear |=> err_flag)
		else $error("error flag dropped");
	err_clear_a: assert property (err_clear && !rx_bad |=> !err_flag)
		else $error("error flag not cleared");
	// Reply bytes stay put until taken; a start launches a reply
	tx_hold_a: assert property (tx_valid && !tx_ready
		|=> tx_valid && $stable(tx_data)) else $error("reply byte moved");
	tx_launch_a: assert property (tx_start && !tx_busy
		|=> tx_busy ##[0:3] tx_valid) else $error("reply not launched");
endmodule : sfc_chk
bind sfc_frame_check sfc_chk chk_u (.ref_clk(ref_clk), .rst(rst),
	.ascii_mode(ascii_mode), .rx_end(rx_end), .rx_good(rx_good),
	.rx_bad(rx_bad), .err_flag(err_flag), .err_clear(err_clear),
	.tx_start(tx_start), .tx_valid(tx_valid), .tx_data(tx_data),
	.tx_ready(tx_ready), .tx_busy(tx_busy));
`default_nettype wire

// File: test/sfc_master.sv
// Purpose: Serial bus master model: sends requests, takes the reply
// Assumes: Caller loads frame before calling send_frame
// Notes:   Slow mode accepts one reply byte in three
`default_nettype none
module sfc_master (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       slow,
	output logic            rx_start,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_end,
	input  wire logic       rx_ready,
	input  wire logic       rx_good,
	input  wire logic       rx_bad,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] frame[$];
	logic [7:0] got[$];
	logic [1:0] ph_reg;
	initial begin
		rx_start = 1'b0;
		rx_valid = 1'b0;
		rx_data  = 8'h00;
		rx_end   = 1'b0;
	end
	// Reply sink; a stalled byte must wait, never be lost
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ph_reg   <= 2'h0;
			tx_ready <= 1'b0;
		end else begin
			if (tx_valid && tx_ready)
				got.push_back(tx_data);
			ph_reg   <= (ph_reg == 2'h2) ? 2'h0 : ph_reg + 2'h1;
			tx_ready <= !slow || (ph_reg == 2'h2);
		end
	end
	// Whole frame out, check last; released data shows inverted
	task automatic send_frame(output logic good);
		@(posedge ref_clk);
		rx_start <= 1'b1;
		@(posedge ref_clk);
		rx_start <= 1'b0;
		foreach (frame[i]) begin
			rx_valid <= 1'b1;
			rx_data  <= frame[i];
			do @(posedge ref_clk); while (!rx_ready);
		end
		rx_valid <= 1'b0;
		rx_data  <= ~rx_data;
		rx_end   <= 1'b1;
		@(posedge ref_clk);
		rx_end <= 1'b0;
		good = 1'bx;
		repeat (12) begin
			@(posedge ref_clk);
			if (rx_good || rx_bad)
				good = rx_good;
		end
	endtask : send_frame
endmodule : sfc_master
`default_nettype wire

// File: test/testbench.sv
// Purpose: Self-checking bench for the frame check block
// Assumes: 25 MHz clock, reset held 20 cycles
// Notes:   Random bytes from an LFSR seeded at 60
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef logic [7:0] sfc_bq_t[$];
	logic       ref_clk = 1'b0, rst = 1'b1, ascii_mode = 1'b0, slow = 1'b0;
	logic       err_clear = 1'b0, tx_start = 1'b0;
	logic [7:0] tx_node = 8'h00, r, name_rom[20];
	logic       rx_start, rx_valid, rx_end, rx_ready, rx_good, rx_bad;
	logic       err_flag, tx_valid, tx_ready, tx_busy;
	logic [7:0] rx_data, rx_func, tx_data, name_data;
	logic [4:0] name_index;
	int         error_cnt = 0, n_tests = 0, cyc = 0;
	sfc_frame_check dut_u (.ref_clk, .rst, .ascii_mode, .rx_start,
		.rx_valid, .rx_data, .rx_end, .rx_ready, .rx_good, .rx_bad,
		.rx_func, .err_flag, .err_clear, .tx_start, .tx_node, .name_data,
		.name_index, .tx_valid, .tx_data, .tx_ready, .tx_busy);
	sfc_master master_u (.ref_clk, .rst, .slow, .rx_start, .rx_valid,
		.rx_data, .rx_end, .rx_ready, .rx_good, .rx_bad, .tx_valid,
		.tx_data, .tx_ready);
	// Name lookup answers at once, as host logic would
	assign name_data = name_rom[name_index];
	always #20 ref_clk = ~ref_clk;
	// Hang guard, well above the expected run
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			print_verdict();
		end
	end
	function automatic logic [7:0] nxt(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : nxt
	function automatic logic [15:0] crc16(input sfc_bq_t q);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[i]) begin
			c[7:0] = c[7:0] ^ q[i];
			repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction : crc16
	function automatic logic [7:0] lrc8(input sfc_bq_t q);
		logic [7:0] s;
		s = 8'h00;
		foreach (q[i]) s = s + q[i];
		return ~s + 8'h01;
	endfunction : lrc8
	function automatic logic [7:0] hexc(input logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
	endfunction : hexc
	task automatic check(input string what, input logic [15:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	// Request with random payload; fault corrupts or swaps the check
	task automatic rx_case(input int len, input logic fault);
		sfc_bq_t m;
		logic [15:0] c, cs;
		logic g, ok;
		logic [7:0] lc;
		m = {};
		repeat (len) begin
			r = nxt(r);
			m.push_back(ascii_mode ? r | 8'h40 : r);
		end
		// A check byte equal to a framing character would be dropped
		lc = lrc8(m) + 8'(fault);
		while (ascii_mode && (lc == 8'h3A || lc == 8'h0D || lc == 8'h0A)) begin
			m[0] = m[0] ^ 8'h01;
			lc = lrc8(m) + 8'(fault);
		end
		master_u.frame = m;
		c  = crc16(m);
		cs = fault ? {c[7:0], c[15:8]} : c;
		// An empty message is too short to be a frame
		ok = (len > 0) && (ascii_mode ? !fault : cs === c);
		if (ascii_mode) begin
			master_u.frame.push_front(8'h3A);
			master_u.frame.push_back(lrc8(m) + 8'(fault));
			master_u.frame.push_back(8'h0D);
			master_u.frame.push_back(8'h0A);
		end else begin
			master_u.frame.push_back(cs[7:0]);
			master_u.frame.push_back(cs[15:8]);
		end
		master_u.send_frame(g);
		@(negedge ref_clk);
		check("verdict", 16'(g), 16'(ok));
		check("error flag", 16'(err_flag), 16'(!ok));
		if (ok) check("function", 16'(rx_func), 16'(m[1]));
		@(posedge ref_clk) err_clear <= 1'b1;
		@(posedge ref_clk) err_clear <= 1'b0;
		@(negedge ref_clk);
		check("flag cleared", 16'(err_flag), 16'h0000);
	endtask : rx_case
	// Identification reply, with a refused second start mid-send
	task automatic tx_case();
		sfc_bq_t b, e;
		logic [15:0] c;
		logic [7:0]  l;
		int n;
		b = {tx_node, 8'h11, 8'h1A, sfc_pkg::SFC_SLAVE_ID[15:8],
			sfc_pkg::SFC_SLAVE_ID[7:0], sfc_pkg::SFC_RUN_IND[15:8],
			sfc_pkg::SFC_RUN_IND[7:0], sfc_pkg::SFC_PRODUCT[15:8],
			sfc_pkg::SFC_PRODUCT[7:0]};
		foreach (name_rom[i]) b.push_back(name_rom[i]);
		c = crc16(b);
		l = lrc8(b);
		e = b;
		if (ascii_mode) begin
			e = {8'h3A};
			foreach (b[i]) e = {e, hexc(b[i][7:4]), hexc(b[i][3:0])};
			e = {e, hexc(l[7:4]), hexc(l[3:0]), 8'h0D, 8'h0A};
		end else
			e = {e, c[7:0], c[15:8]};
		master_u.got.delete();
		@(posedge ref_clk) tx_start <= 1'b1;
		@(posedge ref_clk) tx_start <= 1'b0;
		repeat (5) @(posedge ref_clk);
		tx_start <= 1'b1;
		@(posedge ref_clk) tx_start <= 1'b0;
		for (n = 0; n < 3000 && tx_busy; n++) @(posedge ref_clk);
		repeat (3) @(posedge ref_clk);
		check("reply length", 16'(master_u.got.size()), 16'(e.size()));
		foreach (e[i]) check("reply byte", 16'(master_u.got[i]), 16'(e[i]));
	endtask : tx_case
	// Main sequence: both framings, prompt and stalling master
	initial begin
		r = 8'h3C;
		foreach (name_rom[i]) begin
			r = nxt(r);
			name_rom[i] = r;
		end
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		for (int k = 0; k < 28; k++) begin
			@(posedge ref_clk);
			ascii_mode <= k[0];
			slow       <= k[1];
			r = nxt(r);
			tx_node    <= r;
			@(posedge ref_clk);
			// The first two frames are empty, one per framing
			if (k < 24)
				rx_case((k < 2) ? 0 : 2 + k, k % 3 == 2);
			else
				tx_case();
		end
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
